// ---- src/io_range_irq_pkg.sv ----
package io_range_irq_pkg;

	// ----------------------------------------------------------------
	// Size byte layout of the I/O range list.
	// ----------------------------------------------------------------
	localparam int LEN_SIZE_MSB   = 7;
	localparam int LEN_SIZE_LSB   = 6;
	localparam int ADDR_SIZE_MSB  = 5;
	localparam int ADDR_SIZE_LSB  = 4;
	localparam int COUNT_MSB      = 3;
	localparam int COUNT_LSB      = 0;
	localparam int MAX_RANGES     = 16;

	// Two-bit size codes.
	localparam logic [1:0] SIZE_NONE  = 2'h0;
	localparam logic [1:0] SIZE_ONE   = 2'h1;
	localparam logic [1:0] SIZE_TWO   = 2'h2;
	localparam logic [1:0] SIZE_FOUR  = 2'h3;

	// ----------------------------------------------------------------
	// Interrupt description byte 0 layout.
	// ----------------------------------------------------------------
	localparam int IRQ_SHARE_BIT  = 7;
	localparam int IRQ_PULSE_BIT  = 6;
	localparam int IRQ_LEVEL_BIT  = 5;
	localparam int IRQ_MASK_BIT   = 4;
	localparam int NMI_DEST_BIT   = 0;
	localparam int IO_CHECK_DEST_BIT  = 1;
	localparam int BUS_ERROR_DEST_BIT = 2;
	localparam int VENDOR_DEST_BIT    = 3;
	localparam logic [1:0] IRQ_BYTES_SHORT = 2'h1;
	localparam logic [1:0] IRQ_BYTES_LONG  = 2'h3;

	// ----------------------------------------------------------------
	// Read port and timing.
	// ----------------------------------------------------------------
	localparam logic [7:0] SIZE_BYTE_OFFSET = 8'h00;
	localparam logic [7:0] PAD_BYTE         = 8'h00;
	localparam int CLK_PERIOD_NS  = 100;
	localparam int PULSE_TIME_NS  = 500;
	localparam int PULSE_CYCLES   = (PULSE_TIME_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
	localparam logic [3:0] PULSE_COUNT = 4'(PULSE_CYCLES);

	// ----------------------------------------------------------------
	// Carried groups.
	// ----------------------------------------------------------------
	typedef struct packed {
		logic [1:0] len_size;
		logic [1:0] addr_size;
		logic [3:0] range_count;
	} io_size_byte_t;

	typedef struct packed {
		logic [31:0] start;
		logic [31:0] length_m1;
	} io_range_t;

	typedef struct packed {
		logic        share;
		logic        pulse;
		logic        level;
		logic        mask;
		logic [3:0]  low_nibble;
		logic [15:0] line_mask_bits;
	} intr_request_descriptor_t;

	typedef struct packed {
		logic        valid;
		logic        beyond;
		logic [7:0]  data;
	} rd_answer_t;

	// Bytes that a size code stands for.
	function automatic logic [2:0] size_bytes(input logic [1:0] code);
		logic [2:0] n;
		n = 3'h0;
		unique case (code)
			SIZE_NONE: n = 3'h0;
			SIZE_ONE:  n = 3'h1;
			SIZE_TWO:  n = 3'h2;
			SIZE_FOUR: n = 3'h4;
		endcase
		return n;
	endfunction

	// Keeps only the bytes that a field of the given size carries.
	function automatic logic [31:0] size_mask(input logic [1:0] code);
		logic [31:0] m;
		m = 32'h0000_0000;
		unique case (code)
			SIZE_NONE: m = 32'h0000_0000;
			SIZE_ONE:  m = 32'h0000_00FF;
			SIZE_TWO:  m = 32'h0000_FFFF;
			SIZE_FOUR: m = 32'hFFFF_FFFF;
		endcase
		return m;
	endfunction

endpackage

// ---- src/intr_request_driver.sv ----
`timescale 1ns/1ps

module intr_request_driver (
	input  wire logic clk,
	input  wire logic rst,
	input  wire logic intr_event,
	input  wire logic intr_serviced,
	input  wire logic level_mode_select,
	input  wire logic pulse_capable,
	input  wire logic level_capable,
	output logic      card_intr_request_n,
	output logic      intr_pending
);

	typedef enum logic [1:0] {
		IDLE,
		PULSING,
		HOLDING
	} drv_state_t;

	// The pulse width is fixed in the package so that it tracks the clock period.
	localparam logic [3:0] PULSE_COUNT_LOCAL = io_range_irq_pkg::PULSE_COUNT;

	drv_state_t  state;
	drv_state_t  next_state;
	logic [3:0]  count;
	logic [3:0]  next_count;
	logic        pin_n;
	logic        next_pin_n;

	// ----------------------------------------------------------------
	// Request signalling.
	// ----------------------------------------------------------------

	// Level mode only when the configuration can hold the pin and level is selected; otherwise a short pulse if pulse capable, else nothing.
	always_comb begin
		next_state = state;
		next_count = count;
		next_pin_n = pin_n;
		unique case (state)
			IDLE: begin
				if (intr_event && level_capable && level_mode_select) begin
					next_state = HOLDING;
					next_pin_n = 1'b0;
				end else if (intr_event && pulse_capable) begin
					next_state = PULSING;
					next_count = PULSE_COUNT_LOCAL;
					next_pin_n = 1'b0;
				end
			end
			PULSING: begin
				// Low for a fixed few cycles, then released.
				if (count == 4'h1) begin
					next_state = IDLE;
					next_pin_n = 1'b1;
				end
				next_count = count - 4'h1;
			end
			HOLDING: begin
				// Stays low until software says the interrupt was serviced.
				if (intr_serviced) begin
					next_state = IDLE;
					next_pin_n = 1'b1;
				end
			end
		endcase
	end

	// State registers.
	always_ff @(posedge clk) begin
		if (rst) begin
			state <= IDLE;
			count <= 4'h0;
			pin_n <= 1'b1;
		end else begin
			state <= next_state;
			count <= next_count;
			pin_n <= next_pin_n;
		end
	end

	assign card_intr_request_n = pin_n;
	assign intr_pending        = (state != IDLE);

endmodule // intr_request_driver

// ---- src/io_range_irq_descriptor_decode.sv ----
`timescale 1ns/1ps

// How it works
// - Size byte: length code 7:6, address code 5:4, range count 3:0.
// - Codes mean absent, one, two, four bytes; both zero is flagged.
// - Range count stores ranges minus one, zero meaning one range.
// - Unspecified start and length bits are emitted as zero.
// - Start and length fields are 0/1/2/4 bytes; length is minus one.
// - Interrupt bytes follow straight after the I/O range bytes.
// - Byte 0 bit 7 advertises interrupt sharing support.
// - Pulse capable cards request by a brief low pulse on the pin.
// - Level capable cards hold the pin low until serviced.
// - Level select bit chooses level or pulse signalling when supported.
// - Mask zero: low nibble selects one of sixteen lines, one byte only.
// - Mask one: two more bytes give allowed lines 0-7 and 8-15.
// - Mask one: low nibble allows special destinations, ignored otherwise.

module io_range_irq_descriptor_decode (
	input  wire logic                                       clk,
	input  wire logic                                       rst,
	input  wire logic                                       io_present,
	input  wire logic                                       irq_present,
	input  wire io_range_irq_pkg::io_size_byte_t            io_size,
	input  wire io_range_irq_pkg::io_range_t [15:0]         ranges,
	input  wire io_range_irq_pkg::intr_request_descriptor_t intr_request_descriptor,
	input  wire logic                                       rd_req,
	input  wire logic [7:0]                                 rd_offset,
	output io_range_irq_pkg::rd_answer_t                    rd_answer,
	output logic [7:0]                                      desc_length,
	output logic                                            cfg_error,
	output logic [3:0]                                      single_line_select,
	output logic [15:0]                                     line_mask_bits,
	output logic [3:0]                                      special_dest,
	input  wire logic                                       intr_event,
	input  wire logic                                       intr_serviced,
	input  wire logic                                       level_mode_select,
	output logic                                            card_intr_request_n,
	output logic                                            intr_pending
);

	// ----------------------------------------------------------------
	// Field sizes and layout.
	// ----------------------------------------------------------------

	logic [2:0] addr_bytes;
	logic [2:0] len_bytes;
	logic [3:0] stride;
	logic [4:0] range_total;
	logic [7:0] io_bytes;
	logic [1:0] irq_bytes;
	logic [7:0] total_bytes;
	logic [7:0] size_byte;
	logic [7:0] irq_byte0;

	// Decode the size byte into byte counts for each field.
	always_comb begin
		size_byte   = {io_size.len_size, io_size.addr_size, io_size.range_count};
		addr_bytes  = io_range_irq_pkg::size_bytes(io_size.addr_size);
		len_bytes   = io_range_irq_pkg::size_bytes(io_size.len_size);
		stride      = {1'b0, addr_bytes} + {1'b0, len_bytes};
		range_total = {1'b0, io_size.range_count} + 5'h01;
		io_bytes    = 8'h00;
		if (io_present) begin
			io_bytes = 8'(8'h01 + 8'(range_total) * 8'(stride));
		end
		irq_bytes = 2'h0;
		if (irq_present) begin
			irq_bytes = intr_request_descriptor.mask ? io_range_irq_pkg::IRQ_BYTES_LONG
			                                         : io_range_irq_pkg::IRQ_BYTES_SHORT;
		end
		total_bytes = io_bytes + {6'h00, irq_bytes};
	end

	// Byte 0 of the interrupt description; the nibble means a line or special masks.
	always_comb begin
		irq_byte0 = {intr_request_descriptor.share,
		             intr_request_descriptor.pulse,
		             intr_request_descriptor.level,
		             intr_request_descriptor.mask,
		             intr_request_descriptor.low_nibble};
	end

	// ----------------------------------------------------------------
	// Per-range masked fields.
	// ----------------------------------------------------------------

	logic [31:0] start_masked [15:0];
	logic [31:0] len_masked   [15:0];

	// Bits beyond the declared field widths are forced to zero on the way out.
	generate
		for (genvar g = 0; g < io_range_irq_pkg::MAX_RANGES; g++) begin : g_range
			assign start_masked[g] = ranges[g].start
			                         & io_range_irq_pkg::size_mask(io_size.addr_size);
			assign len_masked[g]   = ranges[g].length_m1
			                         & io_range_irq_pkg::size_mask(io_size.len_size);
		end
	endgenerate

	// ----------------------------------------------------------------
	// Byte lookup.
	// ----------------------------------------------------------------

	logic [7:0] lookup_byte;
	logic       lookup_beyond;

	// Walks the layout in order: size byte, ranges (start then length), interrupt bytes.
	always_comb begin
		logic [7:0] rel;
		logic [7:0] base;
		logic [7:0] field_off;
		logic [7:0] irq_off;
		logic [4:0] shift_sel;
		rel           = 8'h00;
		base          = 8'h00;
		field_off     = 8'h00;
		irq_off       = 8'h00;
		shift_sel     = 5'h00;
		lookup_byte   = io_range_irq_pkg::PAD_BYTE;
		lookup_beyond = 1'b0;
		if (io_present && rd_offset == io_range_irq_pkg::SIZE_BYTE_OFFSET) begin
			lookup_byte = size_byte;
		end else if (io_present && rd_offset < io_bytes) begin
			rel = rd_offset - 8'h01;
			for (int i = 0; i < io_range_irq_pkg::MAX_RANGES; i++) begin
				base = 8'(i) * {4'h0, stride};
				if (5'(i) < range_total && rel >= base && rel < base + {4'h0, stride}) begin
					field_off = rel - base;
					if (field_off < {5'h00, addr_bytes}) begin
						// Start address comes first, least significant byte first.
						shift_sel   = {field_off[1:0], 3'h0};
						lookup_byte = 8'(start_masked[i] >> shift_sel);
					end else begin
						shift_sel   = {2'(field_off - {5'h00, addr_bytes}), 3'h0};
						lookup_byte = 8'(len_masked[i] >> shift_sel);
					end
				end
			end
		end else if (irq_present && rd_offset < total_bytes) begin
			irq_off = rd_offset - io_bytes;
			unique case (irq_off[1:0])
				2'h0:    lookup_byte = irq_byte0;
				2'h1:    lookup_byte = intr_request_descriptor.line_mask_bits[7:0];
				2'h2:    lookup_byte = intr_request_descriptor.line_mask_bits[15:8];
				default: lookup_byte = io_range_irq_pkg::PAD_BYTE;
			endcase
		end else begin
			lookup_beyond = 1'b1;
		end
	end

	// ----------------------------------------------------------------
	// Registered read answer and decoded views.
	// ----------------------------------------------------------------

	io_range_irq_pkg::rd_answer_t next_rd_answer;
	logic [7:0]                   next_desc_length;
	logic                         next_cfg_error;
	logic [3:0]                   next_single_line_select;
	logic [15:0]                  next_line_mask_bits;
	logic [3:0]                   next_special_dest;

	// The answer lands one cycle after the request; data holds until the next request.
	always_comb begin
		next_rd_answer.valid  = rd_req;
		next_rd_answer.beyond = rd_answer.beyond;
		next_rd_answer.data   = rd_answer.data;
		if (rd_req) begin
			next_rd_answer.beyond = lookup_beyond;
			next_rd_answer.data   = lookup_byte;
		end
		next_desc_length = total_bytes;
		// Both sizes zero is an illegal range list.
		next_cfg_error = io_present && io_size.len_size == io_range_irq_pkg::SIZE_NONE
		                 && io_size.addr_size == io_range_irq_pkg::SIZE_NONE;
		next_single_line_select = 4'h0;
		next_line_mask_bits     = 16'h0000;
		next_special_dest       = 4'h0;
		if (irq_present && !intr_request_descriptor.mask) begin
			// One line only; the nibble is a line number, not destination masks.
			next_single_line_select = intr_request_descriptor.low_nibble;
			next_line_mask_bits     = 16'h0001 << intr_request_descriptor.low_nibble;
		end else if (irq_present) begin
			next_line_mask_bits = intr_request_descriptor.line_mask_bits;
			next_special_dest   = intr_request_descriptor.low_nibble;
		end
	end

	// Output registers.
	always_ff @(posedge clk) begin
		if (rst) begin
			rd_answer          <= '0;
			desc_length        <= 8'h00;
			cfg_error          <= 1'b0;
			single_line_select <= 4'h0;
			line_mask_bits     <= 16'h0000;
			special_dest       <= 4'h0;
		end else begin
			rd_answer          <= next_rd_answer;
			desc_length        <= next_desc_length;
			cfg_error          <= next_cfg_error;
			single_line_select <= next_single_line_select;
			line_mask_bits     <= next_line_mask_bits;
			special_dest       <= next_special_dest;
		end
	end

	// ----------------------------------------------------------------
	// Card interrupt request pin.
	// ----------------------------------------------------------------

	// Capabilities advertised in byte 0 gate which signalling the pin may use.
	intr_request_driver u_intr_request_driver (
		.clk                 (clk),
		.rst                 (rst),
		.intr_event          (intr_event && irq_present),
		.intr_serviced       (intr_serviced),
		.level_mode_select   (level_mode_select),
		.pulse_capable       (intr_request_descriptor.pulse),
		.level_capable       (intr_request_descriptor.level),
		.card_intr_request_n (card_intr_request_n),
		.intr_pending        (intr_pending)
	);

endmodule // io_range_irq_descriptor_decode

// ---- dv/io_range_irq_chk.sv ----
`timescale 1ns/1ps

// ----------------------------------------
// Port checker for the descriptor decoder.
// ----------------------------------------
module io_range_irq_chk (
	input wire logic	clk,
	input wire logic	rst,
	input wire logic	io_present,
	input wire logic	irq_present,
	input wire io_range_irq_pkg::io_size_byte_t	io_size,
	input wire io_range_irq_pkg::intr_request_descriptor_t	intr_request_descriptor,
	input wire logic	rd_req,
	input wire logic [7:0]	rd_offset,
	input wire io_range_irq_pkg::rd_answer_t	rd_answer,
	input wire logic [7:0]	desc_length,
	input wire logic	cfg_error,
	input wire logic [3:0]	single_line_select,
	input wire logic [15:0]	line_mask_bits,
	input wire logic [3:0]	special_dest,
	input wire logic	intr_event,
	input wire logic	intr_serviced,
	input wire logic	level_mode_select,
	input wire logic	card_intr_request_n,
	input wire logic	intr_pending
);
	io_range_irq_pkg::intr_request_descriptor_t	d;
	logic		r1;
	logic		lvl;
	logic		st;
	logic [7:0]	exp_len;

	// Own size table, so a slip in the shared helper is not copied here.
	function automatic logic [7:0] sb(input logic [1:0] c);
		return (c == 2'h3) ? 8'h04 : {6'h00, c};
	endfunction

	// The edge after reset is masked because past values still see reset time.
	always_ff @(posedge clk) r1 <= rst;
	assign d = intr_request_descriptor;
	assign lvl = d.level && level_mode_select;
	assign st = intr_event && irq_present && !intr_pending;
	assign exp_len = (io_present ? 8'h01 + (8'(io_size.range_count) + 8'h01) *
		(sb(io_size.addr_size) + sb(io_size.len_size)) : 8'h00) +
		(irq_present ? (d.mask ? 8'h03 : 8'h01) : 8'h00);

	default clocking cb @(posedge clk);
	endclocking
	default disable iff (rst || r1);

	AST_RD_VALID: assert property (rd_req |=> rd_answer.valid)
		else $error("read answer missing");
	AST_BEYOND: assert property (rd_req && $stable(desc_length) |=>
		rd_answer.beyond == $past(rd_offset >= desc_length) &&
		(!rd_answer.beyond || rd_answer.data == 8'h00))
		else $error("beyond flag wrong");
	AST_CFG_ERR: assert property (cfg_error == $past(io_present &&
		io_size.len_size == 2'h0 && io_size.addr_size == 2'h0))
		else $error("config error flag wrong");
	AST_DESC_LEN: assert property (desc_length == $past(exp_len))
		else $error("descriptor length wrong");
	AST_ONE_LINE: assert property ($past(irq_present && !d.mask) |->
		single_line_select == $past(d.low_nibble) && special_dest == 4'h0 &&
		line_mask_bits == (16'h0001 << $past(d.low_nibble)))
		else $error("single line view wrong");
	AST_MASK_LINES: assert property ($past(irq_present && d.mask) |->
		line_mask_bits == $past(d.line_mask_bits) && single_line_select == 4'h0 &&
		special_dest == $past(d.low_nibble))
		else $error("mask view wrong");
	AST_PULSE: assert property (st && d.pulse && !lvl |=>
		!card_intr_request_n [*5] ##1 card_intr_request_n)
		else $error("pulse length wrong");
	AST_LEVEL_HOLD: assert property ((st || !card_intr_request_n &&
		!intr_serviced) && lvl |=> !card_intr_request_n)
		else $error("level request dropped early");
	AST_LEVEL_END: assert property (!card_intr_request_n && intr_serviced && lvl
		|=> card_intr_request_n && !intr_pending)
		else $error("level request not released");
endmodule // io_range_irq_chk

bind io_range_irq_descriptor_decode io_range_irq_chk i_io_range_irq_chk (
	.clk(clk), .rst(rst), .io_present(io_present), .irq_present(irq_present),
	.io_size(io_size), .intr_request_descriptor(intr_request_descriptor),
	.rd_req(rd_req), .rd_offset(rd_offset), .rd_answer(rd_answer),
	.desc_length(desc_length), .cfg_error(cfg_error),
	.single_line_select(single_line_select), .line_mask_bits(line_mask_bits),
	.special_dest(special_dest), .intr_event(intr_event),
	.intr_serviced(intr_serviced), .level_mode_select(level_mode_select),
	.card_intr_request_n(card_intr_request_n), .intr_pending(intr_pending)
);

// ---- dv/host_reader.sv ----
`timescale 1ns/1ps

// ----------------------------------------
// Host side reader of the stored bytes.
// ----------------------------------------
module host_reader (
	input wire logic	clk,
	input wire logic	rst,
	input wire logic	start,
	input wire logic [7:0]	n_bytes,
	input wire io_range_irq_pkg::rd_answer_t	rd_answer,
	output logic		rd_req,
	output logic [7:0]	rd_offset,
	output logic [7:0]	got_cnt,
	output logic [8:0]	got [0:139]
);
	logic [7:0]	idx;

	// The strobe must be defined before the first clock edge.
	initial rd_req = 1'b0;
	initial rd_offset = 8'h00;

	// Offsets go out strictly in order, one per cycle, answers logged as they come.
	always @(posedge clk) begin
		rd_req <= !(rst || start) && idx != n_bytes;
		rd_offset <= idx;
		if (rst || start) begin
			idx <= 8'h00;
			got_cnt <= 8'h00;
		end else begin
			if (idx != n_bytes)
				idx <= idx + 8'h01;
			if (rd_answer.valid) begin
				got[got_cnt] <= {rd_answer.beyond, rd_answer.data};
				got_cnt <= got_cnt + 8'h01;
			end
		end
	end
endmodule // host_reader

// ---- dv/io_range_irq_descriptor_decode_tb.sv ----
`timescale 1ns/1ps

// ----------------------------------------
// Self-checking bench for the decoder.
// ----------------------------------------
module io_range_irq_descriptor_decode_tb;
	localparam int	pulse_len = int'(io_range_irq_pkg::PULSE_COUNT);
	logic		clk = 1'b0;
	logic		rst = 1'b1;
	logic		io_present = 1'b0, irq_present = 1'b0, start = 1'b0;
	logic		intr_event = 1'b0, intr_serviced = 1'b0, level_mode_select = 1'b0;
	logic		card_intr_request_n, intr_pending, cfg_error, rd_req;
	logic [7:0]	rd_offset, desc_length, got_cnt, n_bytes = 8'h00;
	logic [3:0]	single_line_select, special_dest;
	logic [15:0]	line_mask_bits;
	logic [8:0]	got [0:139];
	io_range_irq_pkg::io_size_byte_t	io_size = 8'h00;
	io_range_irq_pkg::io_range_t [15:0]	ranges;
	io_range_irq_pkg::intr_request_descriptor_t	d = 24'h000000;
	io_range_irq_pkg::rd_answer_t	rd_answer;
	int		num_errors = 0, total_checks = 0;

	always #50 clk = ~clk;

	io_range_irq_descriptor_decode i_io_range_irq_descriptor_decode (
		.clk(clk), .rst(rst), .io_present(io_present), .irq_present(irq_present),
		.io_size(io_size), .ranges(ranges), .intr_request_descriptor(d),
		.rd_req(rd_req), .rd_offset(rd_offset), .rd_answer(rd_answer),
		.desc_length(desc_length), .cfg_error(cfg_error),
		.single_line_select(single_line_select), .line_mask_bits(line_mask_bits),
		.special_dest(special_dest), .intr_event(intr_event),
		.intr_serviced(intr_serviced), .level_mode_select(level_mode_select),
		.card_intr_request_n(card_intr_request_n), .intr_pending(intr_pending)
	);
	host_reader i_host_reader (
		.clk(clk), .rst(rst), .start(start), .n_bytes(n_bytes), .rd_answer(rd_answer),
		.rd_req(rd_req), .rd_offset(rd_offset), .got_cnt(got_cnt), .got(got)
	);

	// Case equality, so an unknown never passes.
	task automatic cmp(input logic [31:0] act, input logic [31:0] exp, input string m);
		total_checks++;
		if (act !== exp) begin
			num_errors++;
			$display("[FAIL] %0t %s", $time, m);
		end
	endtask

	function automatic int nb(input logic [1:0] c);
		return (c == 2'h3) ? 4 : int'(c);
	endfunction

	task automatic end_sim;
		$display("errors %0d checks %0d", num_errors, total_checks);
		if (num_errors == 0 && total_checks > 0)
			$display("[ PASS ]");
		else
			$display("[ FAIL ]");
		$finish;
	endtask

	// One layout: expected bytes built here, then read past the end by the host.
	task automatic t_read(input logic [1:0] a, input logic [1:0] l, input logic [3:0] n,
		input logic io, input logic m);
		logic [8:0]	q [$];
		logic [15:0]	lm;
		int		i;
		lm = {~n, n, 4'hA, 4'h5};
		if (io) begin
			q.push_back({1'b0, l, a, n});
			for (int r = 0; r <= n; r++) begin
				for (int b = 0; b < nb(a); b++)
					q.push_back({1'b0, ranges[r].start[8*b +: 8]});
				for (int b = 0; b < nb(l); b++)
					q.push_back({1'b0, ranges[r].length_m1[8*b +: 8]});
			end
		end
		q.push_back({1'b0, n[0], 1'b1, 1'b0, m, n});
		if (m) begin
			q.push_back({1'b0, lm[7:0]});
			q.push_back({1'b0, lm[15:8]});
		end
		q.push_back(9'h100);
		@(posedge clk);
		io_size <= {l, a, n};
		io_present <= io;
		irq_present <= 1'b1;
		d <= {n[0], 1'b1, 1'b0, m, n, lm};
		repeat (2) @(posedge clk);
		#1;
		cmp(desc_length, q.size() - 1, "length");
		cmp(cfg_error, io && a == 2'h0 && l == 2'h0, "cfg error");
		cmp(single_line_select, m ? 4'h0 : n, "line select");
		cmp(line_mask_bits, m ? lm : 16'h0001 << n, "line mask");
		cmp(special_dest, m ? n : 4'h0, "special");
		@(posedge clk);
		n_bytes <= 8'(q.size());
		start <= 1'b1;
		@(posedge clk);
		start <= 1'b0;
		#1;
		for (i = 0; i < 400 && got_cnt !== 8'(q.size()); i++) begin
			@(posedge clk);
			#1;
		end
		cmp(got_cnt, 8'(q.size()), "byte count");
		for (int k = 0; k < q.size(); k++)
			cmp(got[k], q[k], "byte");
		$display("t_read %0d %0d done", a, l);
	endtask

	// Counts low cycles of the pin; a second event lands while pending.
	task automatic t_irq(input logic ip, input logic p, input logic lv, input logic s,
		input int exp);
		int low;
		low = 0;
		@(posedge clk);
		irq_present <= ip;
		d <= {1'b0, p, lv, 1'b0, 4'h3, 16'h0000};
		level_mode_select <= s;
		intr_event <= 1'b1;
		for (int i = 0; i < 30; i++) begin
			@(posedge clk);
			intr_event <= (i == 1);
			intr_serviced <= (i == 11);
			#1;
			if (card_intr_request_n === 1'b0)
				low++;
		end
		cmp(low, exp, "low cycles");
		cmp(intr_pending, 1'b0, "pending");
		$display("t_irq %0d done", exp);
	endtask

	// Main sequence: reset, every size code pair (pair 1/1 read with no I/O list), then the pin modes.
	initial begin
		for (int i = 0; i < 16; i++)
			ranges[i] = {32'h4433_2210 + 32'(i), 32'h8877_6650 + 32'(i)};
		repeat (2) @(posedge clk);
		rst <= 1'b0;
		#1;
		cmp(card_intr_request_n, 1'b1, "reset pin");
		cmp({rd_answer, desc_length, cfg_error, intr_pending}, 0, "reset state");
		for (int k = 0; k < 16; k++)
			t_read(k[3:2], k[1:0], 4'(15 - k), k != 5, k[0]);
		t_irq(1'b1, 1'b1, 1'b0, 1'b0, pulse_len);
		t_irq(1'b1, 1'b1, 1'b1, 1'b1, 12);
		t_irq(1'b1, 1'b1, 1'b1, 1'b0, pulse_len);
		t_irq(1'b1, 1'b0, 1'b1, 1'b0, 0);
		t_irq(1'b0, 1'b1, 1'b0, 1'b0, 0);
		end_sim;
	end

	// Watchdog well beyond the few hundred cycles the tests need.
	initial begin
		#2000000;
		num_errors++;
		$display("[FAIL] %0t watchdog", $time);
		end_sim;
	end
endmodule // io_range_irq_descriptor_decode_tb
